// >>> shared/kasf_pkg.sv
package kasf_pkg;
    // --------------------------------------------------------------
    // control characters
    // --------------------------------------------------------------
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [7:0] CH_DLE = 8'h10;
    localparam logic [7:0] CH_NAK = 8'h15;
    // --------------------------------------------------------------
    // frame limits and timing
    // --------------------------------------------------------------
    localparam logic [7:0] MAX_MSG = 8'h80;
    localparam logic [7:0] IDX_SAT = 8'hFF;
    localparam logic [2:0] MAX_TRIES = 3'h6;
    localparam int CLK_KHZ = 250000;
    localparam int ADT_MS = 2000;
    localparam int CDT_MS = 100;
    localparam int ADT_CYCLES = ADT_MS * CLK_KHZ;
    localparam int CDT_CYCLES = CDT_MS * CLK_KHZ;
    // --------------------------------------------------------------
    // types
    // --------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } kasf_byte_t;

    typedef enum logic [14:0] {
        ST_IDLE   = 15'h0001,
        ST_R_ACK  = 15'h0002,
        ST_R_DATA = 15'h0004,
        ST_R_DLE  = 15'h0008,
        ST_R_BCC  = 15'h0010,
        ST_R_REPL = 15'h0020,
        ST_S_STX  = 15'h0040,
        ST_S_WT1  = 15'h0080,
        ST_S_DATA = 15'h0100,
        ST_S_DUP  = 15'h0200,
        ST_S_DLE  = 15'h0400,
        ST_S_ETX  = 15'h0800,
        ST_S_BCC  = 15'h1000,
        ST_S_WT2  = 15'h2000,
        ST_S_ABRT = 15'h4000
    } kasf_st_t;

    typedef struct packed {
        kasf_st_t st;
        logic tx_valid;
        logic [7:0] tx_data;
        kasf_byte_t core;
        logic frame_ok;
        logic frame_bad;
        logic send_done;
        logic send_fail;
        logic busy;
        logic lamp_green;
        logic lamp_yellow;
        logic key_present;
        logic [7:0] bcc;
        logic [7:0] idx;
        logic [7:0] count;
        logic [7:0] slen;
        logic err;
        logic [2:0] tries;
        logic [31:0] t;
    } kasf_state_t;
endpackage : kasf_pkg

// >>> rtl/kasf_top.sv
// Contract
// (RL1) green lamp when powered, ready, no key
// (RL2) detected key switches lamp to yellow
// (RL3) key-present output rises with yellow lamp
// (RL4) core framed by STX and DLE ETX BCC
// (RL5) byte 0 is count, at most 128
// (RL6) core layout: id, address, start, items, data
// (RL7) answer frame with DLE or NAK
// (RL8) negative answer repeats from STX
// (RL9) abort after six attempts in total
// (RL10) BCC is xor of core through ETX
// (RL11) core byte 10h doubled, receiver collapses
// (RL12) no acknowledgement within delay fails attempt
// (RL13) character gap beyond delay fails reception
// (RL14) key removed drops output, lamp green
module kasf_top #(
    parameter int ADT_CYC = kasf_pkg::ADT_CYCLES,
    parameter int CDT_CYC = kasf_pkg::CDT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic power_ready,
    input wire logic key_detect,
    input wire kasf_pkg::kasf_byte_t rx_in,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output kasf_pkg::kasf_byte_t core_out,
    output logic frame_ok,
    output logic frame_bad,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic send_start,
    input wire logic [7:0] send_len,
    output logic send_done,
    output logic send_fail,
    output logic busy,
    output logic lamp_green,
    output logic lamp_yellow,
    output logic key_present
);
    // --------------------------------------------------------------
    // send buffer
    // --------------------------------------------------------------
    logic [7:0] mem [0:255];
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    kasf_pkg::kasf_state_t s;
    kasf_pkg::kasf_state_t next_s;
    logic [7:0] emit;
    logic sent;
    logic rxv;
    logic [7:0] rxb;

    assign sent = s.tx_valid && tx_ready;
    assign rxv = rx_in.valid;
    assign rxb = rx_in.data;

    always_comb
    begin
        next_s = s;
        emit = 8'h00;
        next_s.core.valid = 1'b0;
        next_s.frame_ok = 1'b0;
        next_s.frame_bad = 1'b0;
        next_s.send_done = 1'b0;
        next_s.send_fail = 1'b0;
        next_s.t = s.t + 32'h1;
        // lamp and key output
        next_s.lamp_green = power_ready && !key_detect; // [RL1] [RL14]
        next_s.lamp_yellow = power_ready && key_detect; // [RL2]
        next_s.key_present = power_ready && key_detect; // [RL3] [RL14]
        case (s.st)
            kasf_pkg::ST_S_STX: emit = kasf_pkg::CH_STX; // [RL4]
            kasf_pkg::ST_S_DATA: emit = mem[s.idx];
            kasf_pkg::ST_S_DUP: emit = kasf_pkg::CH_DLE; // [RL11]
            kasf_pkg::ST_S_DLE: emit = kasf_pkg::CH_DLE;
            kasf_pkg::ST_S_ETX: emit = kasf_pkg::CH_ETX;
            kasf_pkg::ST_S_BCC: emit = s.bcc; // [RL10]
            kasf_pkg::ST_S_ABRT: emit = kasf_pkg::CH_NAK;
            kasf_pkg::ST_R_ACK: emit = kasf_pkg::CH_DLE; // [RL7]
            kasf_pkg::ST_R_REPL: emit = s.err ? kasf_pkg::CH_NAK : kasf_pkg::CH_DLE; // [RL7]
            default: emit = 8'h00;
        endcase
        if (!s.tx_valid && s.st != kasf_pkg::ST_IDLE && s.st != kasf_pkg::ST_R_DATA
            && s.st != kasf_pkg::ST_R_DLE && s.st != kasf_pkg::ST_R_BCC
            && s.st != kasf_pkg::ST_S_WT1 && s.st != kasf_pkg::ST_S_WT2
            && !(s.st == kasf_pkg::ST_S_DATA && s.idx == s.slen))
        begin
            next_s.tx_valid = 1'b1;
            next_s.tx_data = emit;
        end
        if (sent)
        begin
            next_s.tx_valid = 1'b0;
        end
        case (s.st)
            kasf_pkg::ST_IDLE:
            begin
                next_s.busy = 1'b0;
                if (send_start)
                begin
                    next_s.st = kasf_pkg::ST_S_STX;
                    next_s.slen = send_len;
                    next_s.tries = 3'h1;
                    next_s.busy = 1'b1;
                end
                else if (rxv && rxb == kasf_pkg::CH_STX)
                begin
                    next_s.st = kasf_pkg::ST_R_ACK;
                    next_s.busy = 1'b1;
                end
            end
            // ----------------------------------------------------------
            // receive path
            // ----------------------------------------------------------
            kasf_pkg::ST_R_ACK:
            begin
                if (sent)
                begin
                    next_s.st = kasf_pkg::ST_R_DATA;
                    next_s.bcc = 8'h00;
                    next_s.idx = 8'h00;
                    next_s.err = 1'b0;
                    next_s.t = 32'h0;
                end
            end
            kasf_pkg::ST_R_DATA, kasf_pkg::ST_R_DLE, kasf_pkg::ST_R_BCC:
            begin
                if (rxv)
                begin
                    next_s.t = 32'h0;
                    if (s.st != kasf_pkg::ST_R_BCC)
                    begin
                        next_s.bcc = s.bcc ^ rxb; // [RL10]
                    end
                    if (s.st == kasf_pkg::ST_R_BCC)
                    begin
                        next_s.err = s.err || (rxb != s.bcc); // [RL10]
                        next_s.st = kasf_pkg::ST_R_REPL;
                    end
                    else if (s.st == kasf_pkg::ST_R_DATA && rxb == kasf_pkg::CH_DLE)
                    begin
                        next_s.st = kasf_pkg::ST_R_DLE;
                    end
                    else if (s.st == kasf_pkg::ST_R_DLE && rxb == kasf_pkg::CH_ETX)
                    begin
                        next_s.st = kasf_pkg::ST_R_BCC; // [RL4]
                    end
                    else if (s.st == kasf_pkg::ST_R_DLE && rxb != kasf_pkg::CH_DLE)
                    begin
                        next_s.err = 1'b1;
                        next_s.st = kasf_pkg::ST_R_DATA;
                    end
                    else
                    begin
                        // doubled 10h collapses to one data byte [RL11]
                        next_s.st = kasf_pkg::ST_R_DATA;
                        next_s.core.valid = 1'b1;
                        next_s.core.data = rxb; // [RL6]
                        if (s.idx == 8'h00)
                        begin
                            next_s.count = rxb;
                            next_s.err = s.err || (rxb > kasf_pkg::MAX_MSG); // [RL5]
                        end
                        if (s.idx > kasf_pkg::MAX_MSG)
                        begin
                            next_s.err = 1'b1; // [RL5]
                        end
                        if (s.idx != kasf_pkg::IDX_SAT)
                        begin
                            next_s.idx = s.idx + 8'h1;
                        end
                    end
                end
                else if (s.t >= 32'(CDT_CYC - 1))
                begin
                    next_s.err = 1'b1; // [RL13]
                    next_s.st = kasf_pkg::ST_R_REPL;
                end
            end
            kasf_pkg::ST_R_REPL:
            begin
                if (sent)
                begin
                    next_s.frame_ok = !s.err;
                    next_s.frame_bad = s.err;
                    next_s.st = kasf_pkg::ST_IDLE;
                end
            end
            // ----------------------------------------------------------
            // send path
            // ----------------------------------------------------------
            kasf_pkg::ST_S_STX:
            begin
                if (sent)
                begin
                    next_s.st = kasf_pkg::ST_S_WT1;
                    next_s.t = 32'h0;
                end
            end
            kasf_pkg::ST_S_WT1, kasf_pkg::ST_S_WT2:
            begin
                if (rxv && rxb == kasf_pkg::CH_DLE)
                begin
                    next_s.idx = 8'h00;
                    next_s.bcc = 8'h00;
                    next_s.st = (s.st == kasf_pkg::ST_S_WT1) ? kasf_pkg::ST_S_DATA : kasf_pkg::ST_IDLE;
                    next_s.send_done = (s.st == kasf_pkg::ST_S_WT2);
                end
                else if (rxv || s.t >= 32'(ADT_CYC - 1)) // [RL12]
                begin
                    if (s.tries == kasf_pkg::MAX_TRIES)
                    begin
                        next_s.st = kasf_pkg::ST_S_ABRT; // [RL9]
                    end
                    else
                    begin
                        next_s.tries = s.tries + 3'h1;
                        next_s.st = kasf_pkg::ST_S_STX; // [RL8]
                    end
                end
            end
            kasf_pkg::ST_S_DATA:
            begin
                if (s.idx == s.slen)
                begin
                    next_s.st = kasf_pkg::ST_S_DLE;
                end
                else if (sent)
                begin
                    next_s.bcc = s.bcc ^ s.tx_data; // [RL10]
                    if (s.tx_data == kasf_pkg::CH_DLE)
                    begin
                        next_s.st = kasf_pkg::ST_S_DUP; // [RL11]
                    end
                    else
                    begin
                        next_s.idx = s.idx + 8'h1;
                    end
                end
            end
            kasf_pkg::ST_S_DUP, kasf_pkg::ST_S_DLE, kasf_pkg::ST_S_ETX:
            begin
                if (sent)
                begin
                    next_s.bcc = s.bcc ^ s.tx_data; // [RL10]
                    if (s.st == kasf_pkg::ST_S_DUP)
                    begin
                        next_s.idx = s.idx + 8'h1;
                        next_s.st = kasf_pkg::ST_S_DATA;
                    end
                    else
                    begin
                        next_s.st = (s.st == kasf_pkg::ST_S_DLE) ? kasf_pkg::ST_S_ETX : kasf_pkg::ST_S_BCC;
                    end
                end
            end
            kasf_pkg::ST_S_BCC:
            begin
                if (sent)
                begin
                    next_s.st = kasf_pkg::ST_S_WT2;
                    next_s.t = 32'h0;
                end
            end
            kasf_pkg::ST_S_ABRT:
            begin
                if (sent)
                begin
                    next_s.send_fail = 1'b1;
                    next_s.st = kasf_pkg::ST_IDLE;
                end
            end
            default: next_s.st = kasf_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s <= '0;
            s.st <= kasf_pkg::ST_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign tx_valid = s.tx_valid;
    assign tx_data = s.tx_data;
    assign core_out = s.core;
    assign frame_ok = s.frame_ok;
    assign frame_bad = s.frame_bad;
    assign send_done = s.send_done;
    assign send_fail = s.send_fail;
    assign busy = s.busy;
    assign lamp_green = s.lamp_green;
    assign lamp_yellow = s.lamp_yellow;
    assign key_present = s.key_present;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence seq_fail_ack;
        (s.st == kasf_pkg::ST_S_WT1 || s.st == kasf_pkg::ST_S_WT2) && !(rxv && rxb == kasf_pkg::CH_DLE)
            && (rxv || s.t >= 32'(ADT_CYC - 1));
    endsequence
    sequence seq_stx_out;
        s.st == kasf_pkg::ST_S_STX ##1 tx_valid && tx_data == kasf_pkg::CH_STX;
    endsequence

    a_green_ready: assert property (resetn && power_ready && !key_detect |=> lamp_green && !lamp_yellow) // [RL1]
        else $error("green lamp missing");
    a_key_yellow: assert property (resetn && power_ready && key_detect |=> lamp_yellow && !lamp_green) // [RL2]
        else $error("yellow lamp missing");
    a_out_lamp: assert property (key_present == lamp_yellow) // [RL3]
        else $error("key output differs from lamp");
    a_key_drop: assert property ($fell(key_detect) |=> !key_present) // [RL14]
        else $error("key output not dropped");
    a_start_stx: assert property (s.st == kasf_pkg::ST_IDLE && send_start |=> seq_stx_out) // [RL4]
        else $error("frame not opened with STX");
    a_ack_stx: assert property (s.st == kasf_pkg::ST_IDLE && !send_start && rxv && rxb == kasf_pkg::CH_STX
        |=> ##1 tx_valid && tx_data == kasf_pkg::CH_DLE) // [RL7]
        else $error("setup not acknowledged");
    a_retry_setup: assert property (seq_fail_ack ##0 (s.tries < kasf_pkg::MAX_TRIES)
        |=> s.st == kasf_pkg::ST_S_STX && s.tries == $past(s.tries) + 3'h1) // [RL8]
        else $error("no repeat from STX");
    a_abort_six: assert property (seq_fail_ack ##0 (s.tries == kasf_pkg::MAX_TRIES)
        |=> s.st == kasf_pkg::ST_S_ABRT ##[1:1000] send_fail) // [RL9]
        else $error("no abort after six");
    a_dup_dle: assert property (s.st == kasf_pkg::ST_S_DATA && sent && tx_data == kasf_pkg::CH_DLE
        |=> ##1 tx_valid && tx_data == kasf_pkg::CH_DLE) // [RL11]
        else $error("10h not doubled");
    a_bcc_out: assert property (s.st == kasf_pkg::ST_S_BCC && tx_valid |-> tx_data == s.bcc) // [RL10]
        else $error("wrong block check");
    a_len_limit: assert property (frame_ok |-> $past(s.count) <= kasf_pkg::MAX_MSG) // [RL5]
        else $error("oversize frame accepted");
    a_gap_nak: assert property (s.st == kasf_pkg::ST_R_DATA && !rxv && s.t >= 32'(CDT_CYC - 1)
        |=> s.st == kasf_pkg::ST_R_REPL ##1 tx_data == kasf_pkg::CH_NAK) // [RL13]
        else $error("gap not refused");
    a_ack_timeout: assert property ((s.st == kasf_pkg::ST_S_WT1 || s.st == kasf_pkg::ST_S_WT2) && !rxv
        && s.t >= 32'(ADT_CYC - 1)
        |=> s.st == kasf_pkg::ST_S_STX || s.st == kasf_pkg::ST_S_ABRT) // [RL12]
        else $error("ack timeout ignored");
endmodule : kasf_top

// >>> bench/kasf_host_model.sv
module kasf_host_model (
    input wire logic clk,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output kasf_pkg::kasf_byte_t rx_in,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow = 1'b0;
    logic miss = 1'b0;
    logic [7:0] got[$];
    initial
    begin
        rx_in = '0;
    end
    // --------------------------------------------------------------
    // link capture, optional stalling
    // --------------------------------------------------------------
    always @(posedge clk)
    begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
    end
    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic put(input logic [7:0] c);
        @(posedge clk);
        rx_in <= '{valid: 1'b1, data: c};
        @(posedge clk);
        rx_in <= '{valid: 1'b0, data: ~c};
    endtask : put

    task automatic take(output logic [7:0] c, input int lim);
        c = 8'hXX;
        miss = 1'b1;
        repeat (lim)
        begin
            @(posedge clk);
            #1;
            if (got.size() > 0)
            begin
                c = got.pop_front();
                miss = 1'b0;
                return;
            end
        end
    endtask : take

    // flip corrupts the block check on purpose
    task automatic send_frame(input logic [7:0] core[$], input logic [7:0] flip, output logic [7:0] ans);
        logic [7:0] bcc;
        bcc = 8'h00;
        put(kasf_pkg::CH_STX);
        take(ans, 300);
        if (ans !== kasf_pkg::CH_DLE)
            return;
        foreach (core[i])
        begin
            put(core[i]);
            bcc ^= core[i];
            if (core[i] == kasf_pkg::CH_DLE)
            begin
                put(core[i]);
                bcc ^= core[i];
            end
        end
        put(kasf_pkg::CH_DLE);
        put(kasf_pkg::CH_ETX);
        put(bcc ^ kasf_pkg::CH_DLE ^ kasf_pkg::CH_ETX ^ flip);
        take(ans, 300);
    endtask : send_frame

    task automatic recv_frame(output logic [7:0] core[$], output logic ok, input logic [7:0] reply);
        logic [7:0] c;
        logic [7:0] bcc;
        bcc = 8'h00;
        ok = 1'b0;
        core = {};
        take(c, 300);
        if (c !== kasf_pkg::CH_STX)
            return;
        put(kasf_pkg::CH_DLE);
        forever
        begin
            take(c, 300);
            if (miss)
                return;
            bcc ^= c;
            if (c === kasf_pkg::CH_DLE)
            begin
                take(c, 300);
                bcc ^= c;
                if (c === kasf_pkg::CH_ETX)
                    break;
            end
            core.push_back(c);
        end
        take(c, 300);
        ok = (c === bcc);
        put(reply);
    endtask : recv_frame
endmodule : kasf_host_model

// >>> bench/kasf_top_tb_top.sv
module kasf_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    localparam int ADT = 200;
    localparam int CDT = 50;
    typedef struct packed {logic pwr; logic key; logic [2:0] exp;} kasf_row_t;
    kasf_row_t rows[7] = '{'{1'b1, 1'b0, 3'h4}, '{1'b1, 1'b1, 3'h3}, '{1'b1, 1'b0, 3'h4},
        '{1'b0, 1'b1, 3'h0}, '{1'b1, 1'b1, 3'h3}, '{1'b0, 1'b0, 3'h0}, '{1'b1, 1'b0, 3'h4}};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic power_ready = 1'b1;
    logic key_detect = 1'b0;
    logic wr_en = 1'b0;
    logic send_start = 1'b0;
    logic [7:0] wr_addr = 8'h00, wr_data = 8'h00, send_len = 8'h00, tx_data, c;
    kasf_pkg::kasf_byte_t rx_in, core_out;
    logic tx_ready, tx_valid, frame_ok, frame_bad, send_done, send_fail, busy, ok;
    logic lamp_green, lamp_yellow, key_present;
    int errors = 0, check_count = 0, cycles = 0, n_ok = 0, n_bad = 0, n_done = 0, n_fail = 0, t0;
    logic [7:0] seen[$];
    logic [7:0] rcv[$];
    logic [7:0] frm[$] = '{8'h08, 8'h54, 8'h57, 8'h01, 8'h00, 8'h20, 8'h01, 8'h10};

    kasf_top #(.ADT_CYC(ADT), .CDT_CYC(CDT)) DUT (.clk(clk), .resetn(resetn), .power_ready(power_ready),
        .key_detect(key_detect), .rx_in(rx_in), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .core_out(core_out), .frame_ok(frame_ok), .frame_bad(frame_bad), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .send_start(send_start), .send_len(send_len), .send_done(send_done),
        .send_fail(send_fail), .busy(busy), .lamp_green(lamp_green), .lamp_yellow(lamp_yellow),
        .key_present(key_present));
    kasf_host_model host (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .rx_in(rx_in), .tx_ready(tx_ready));

    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (core_out.valid === 1'b1)
            seen.push_back(core_out.data);
        if (frame_ok === 1'b1)
            n_ok++;
        if (frame_bad === 1'b1)
            n_bad++;
        if (send_done === 1'b1)
            n_done++;
        if (send_fail === 1'b1)
            n_fail++;
        if (cycles == 20000)
        begin
            errors++;
            summarize();
        end
    end
    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic cmp(input logic [7:0] q[$]);
        check(8'(q.size()), 8'(frm.size()), "core length");
        foreach (frm[i])
            check(q[i], frm[i], "core byte");
    endtask : cmp

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    // --------------------------------------------------------------
    // sequence
    // --------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        check({6'h00, lamp_green, tx_valid}, 8'h00, "reset outputs");
        @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i])
        begin
            @(posedge clk);
            power_ready <= rows[i].pwr;
            key_detect <= rows[i].key;
            repeat (2) @(posedge clk);
            #1;
            check({5'h00, lamp_green, lamp_yellow, key_present}, {5'h00, rows[i].exp}, "lamp");
        end
        host.send_frame(frm, 8'h00, c);
        check(c, kasf_pkg::CH_DLE, "good frame answer");
        repeat (3) @(posedge clk);
        cmp(seen);
        check(8'(n_ok), 8'h01, "frame ok pulse");
        host.send_frame(frm, 8'h01, c);
        check(c, kasf_pkg::CH_NAK, "bad check answer");
        frm[0] = 8'h81;
        host.send_frame(frm, 8'h00, c);
        check(c, kasf_pkg::CH_NAK, "oversize count answer");
        frm[0] = 8'h08;
        host.put(kasf_pkg::CH_STX);
        host.take(c, 300);
        host.put(8'h03);
        t0 = cycles;
        host.take(c, 300);
        check(c, kasf_pkg::CH_NAK, "gap answer");
        check(8'(cycles - t0 >= CDT), 8'h01, "gap not early");
        host.put(kasf_pkg::CH_STX);
        host.take(c, 300);
        host.put(kasf_pkg::CH_DLE);
        host.put(8'h41);
        host.put(kasf_pkg::CH_DLE);
        host.put(kasf_pkg::CH_ETX);
        host.put(8'h42);
        host.take(c, 300);
        check(c, kasf_pkg::CH_NAK, "bad escape answer");
        repeat (3) @(posedge clk);
        check(8'(n_bad), 8'h04, "frame bad pulses");
        foreach (frm[i])
        begin
            @(posedge clk);
            wr_en <= 1'b1;
            wr_addr <= 8'(i);
            wr_data <= frm[i];
        end
        @(posedge clk);
        wr_en <= 1'b0;
        send_len <= 8'h08;
        send_start <= 1'b1;
        @(posedge clk);
        send_start <= 1'b0;
        #1;
        check({7'h00, busy}, 8'h01, "busy"); 
        host.slow = 1'b1;
        host.recv_frame(rcv, ok, kasf_pkg::CH_NAK);
        check({7'h00, ok}, 8'h01, "sent check");
        cmp(rcv);
        host.recv_frame(rcv, ok, kasf_pkg::CH_DLE);
        cmp(rcv);
        repeat (4) @(posedge clk);
        check(8'(n_done), 8'h01, "send done");
        host.slow = 1'b0;
        @(posedge clk);
        send_start <= 1'b1;
        @(posedge clk);
        send_start <= 1'b0;
        for (int k = 1; k <= 6; k++)
        begin
            host.take(c, 400);
            check(c, kasf_pkg::CH_STX, "attempt start");
            if (k == 3)
                check(8'(cycles - t0 >= ADT), 8'h01, "ack wait not early");
            t0 = cycles;
            if (k == 1)
                host.put(kasf_pkg::CH_NAK);
        end
        host.take(c, 400);
        check(c, kasf_pkg::CH_NAK, "abort answer");
        repeat (4) @(posedge clk);
        check(8'(n_fail), 8'h01, "send fail");
        check(8'(n_done), 8'h01, "no extra done");
        @(posedge clk);
        send_start <= 1'b1;
        @(posedge clk);
        send_start <= 1'b0;
        host.take(c, 400);
        check(c, kasf_pkg::CH_STX, "attempt before reset");
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({5'h00, busy, tx_valid, lamp_green}, 8'h00, "mid-run reset");
        @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check({6'h00, lamp_green, busy}, 8'h02, "after reset");
        host.send_frame(frm, 8'h00, c);
        check(c, kasf_pkg::CH_DLE, "frame after reset");
        repeat (3) @(posedge clk);
        check(8'(n_ok), 8'h02, "frame ok after reset");
        summarize();
    end
endmodule : kasf_top_tb_top
